/* logic/rps_cfg.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  rail power-down sequencer.
  Assumes a 20 MHz core clock and word-aligned Avalon byte addressing.
*/
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define RPS_NUM_RAILS      7
`define RPS_SLOT_W         3
`define RPS_RAIL_W         3
`define RPS_SLOT_MAX       3'h7
`define RPS_SLOT_RESET     3'h0

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define RPS_IDX_FIRST_BUCK 8'h5F
`define RPS_IDX_SECOND_BUCK 8'h60
`define RPS_IDX_THIRD_BUCK 8'h61
`define RPS_IDX_FIRST_LIN  8'h62
`define RPS_IDX_SECOND_LIN 8'h63
`define RPS_IDX_THIRD_LIN  8'h64
`define RPS_IDX_MEM_REF    8'h65
`define RPS_IDX_STATUS     8'h6A

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define RPS_ST_SLOT_LSB    0
`define RPS_ST_BUSY_BIT    3
`define RPS_ST_BYPASS_BIT  4
`define RPS_ST_DONE_BIT    5
`define RPS_ST_SYSON_BIT   6
`define RPS_ST_OFF_LSB     8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RPS_CLK_FREQ_MHZ   20
`define RPS_STEP_TIME_US   1000
`define RPS_STEP_CYCLES    (`RPS_STEP_TIME_US * `RPS_CLK_FREQ_MHZ)

`endif

/* logic/rps_pkg.sv */
/*
  Types of the rail power-down sequencer.
  Assumes rps_cfg.svh supplies all numeric settings.
*/
package rps_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_STEP = 4'h2,
    SEQ_HOLD = 4'h4,
    SEQ_DONE = 4'h8
  } rps_seq_state_t;

  // Bus slave phases
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'h1,
    BUS_FETCH = 3'h2,
    BUS_ANSW  = 3'h4
  } rps_bus_state_t;

endpackage : rps_pkg

/* logic/rps_slot_if.sv */
/*
  Carrier between the sequencer core and its slot register bank.
  Assumes both ends share core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface rps_slot_if #(
  parameter int RAILS = 7,
  parameter int SW    = 3,
  parameter int RW    = 3
);
  logic [RAILS*SW-1:0] slots;
  logic [RAILS*SW-1:0] loadData;
  logic                loadEn;
  logic                wrEn;
  logic [RW-1:0]       wrRail;
  logic [SW-1:0]       wrData;
  logic [RW-1:0]       rdRail;
  logic [SW-1:0]       rdData;

  modport ctrl (
    output loadEn, loadData, wrEn, wrRail, wrData, rdRail,
    input  slots, rdData
  );
  modport bank (
    input  loadEn, loadData, wrEn, wrRail, wrData, rdRail,
    output slots, rdData
  );
endinterface : rps_slot_if

`default_nettype wire

/* logic/rps_slot_mem.sv */
/*
  Power-down slot register bank, one slot field per rail.
  Assumes the core never asserts load and write together with
  different intent; load wins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"

module rps_slot_mem #(
  parameter int RAILS = `RPS_NUM_RAILS,
  parameter int SW    = `RPS_SLOT_W,
  parameter int RW    = `RPS_RAIL_W
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Core side
  rps_slot_if.bank  port
);

  logic [SW-1:0] slotArr [RAILS];

  // ----------------------------------------------------------------
  // Slot storage
  // ----------------------------------------------------------------
  for (genvar g = 0; g < RAILS; g++) begin : g_slot
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        slotArr[g] <= `RPS_SLOT_RESET;
      end else if (port.loadEn) begin
        slotArr[g] <= port.loadData[g*SW +: SW]; // see [R04]
      end else if (port.wrEn && port.wrRail == RW'(g)) begin
        slotArr[g] <= port.wrData;
      end
    end
    assign port.slots[g*SW +: SW] = slotArr[g];
  end

  // ----------------------------------------------------------------
  // Registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port.rdData <= '0;
    end else if (port.rdRail < RW'(RAILS)) begin
      port.rdData <= slotArr[port.rdRail];
    end else begin
      port.rdData <= '0;
    end
  end

endmodule : rps_slot_mem

`default_nettype wire

/* logic/rps_sequencer.sv */
/*
  Rail power-down sequencer with its slot registers on Avalon-MM.
  Assumes powerDownReq, systemOn, cfgLoad and fusedOnSlots come from
  logic on core_clk, so none of them is synchronised here.
*/
// The Avalon-MM register port was left to the implementer.
// Summary of operation
// [R01] Turn rails off from highest slot downward
// [R02] All slots zero: all rails off together
// [R03] Three-bit slot in low bits, rest unused
// [R04] Config load copies power-up slot into slot
// [R05] Host rewrites slots only while system on
// [R06] Power-up order set only by fuse load
// [R07] Equal slots off together, one interval each
`timescale 1ns/1ps
`default_nettype none
`include "rps_cfg.svh"

module rps_sequencer #(
  parameter int STEP_CYCLES = `RPS_STEP_CYCLES,
  parameter int CNT_W       = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // System state and trigger
  input  wire logic        systemOn,
  input  wire logic        powerDownReq,
  // Configuration load
  input  wire logic        cfgLoad,
  input  wire logic [20:0] fusedOnSlots,
  // Rail controls and state
  output logic      [6:0]  railOff,
  output logic             seqBusy,
  output logic      [20:0] upOrderSlots
);

  localparam int RAILS = `RPS_NUM_RAILS;
  localparam int SW    = `RPS_SLOT_W;
  localparam int RW    = `RPS_RAIL_W;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Bit 3 flags a slot register, bits 2:0 give the rail
  function automatic logic [3:0] decodeRail(input logic [7:0] idx);
    case (idx)
      `RPS_IDX_FIRST_BUCK:  decodeRail = 4'h8;
      `RPS_IDX_SECOND_BUCK: decodeRail = 4'h9;
      `RPS_IDX_THIRD_BUCK:  decodeRail = 4'hA;
      `RPS_IDX_FIRST_LIN:   decodeRail = 4'hB;
      `RPS_IDX_SECOND_LIN:  decodeRail = 4'hC;
      `RPS_IDX_THIRD_LIN:   decodeRail = 4'hD;
      `RPS_IDX_MEM_REF:     decodeRail = 4'hE;
      default:              decodeRail = 4'h0;
    endcase
  endfunction : decodeRail

  logic [7:0] reqIdx;
  logic [3:0] reqRail;
  logic       reqAligned;

  assign reqIdx     = avs_address[9:2];
  assign reqAligned = (avs_address[1:0] == 2'h0);
  assign reqRail    = decodeRail(reqIdx);

  // ----------------------------------------------------------------
  // Slot register bank
  // ----------------------------------------------------------------
  rps_slot_if #(.RAILS(RAILS), .SW(SW), .RW(RW)) slotBus ();

  rps_slot_mem #(
    .RAILS (RAILS),
    .SW    (SW),
    .RW    (RW)
  ) u_slot_mem (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .port     (slotBus.bank)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  rps_pkg::rps_seq_state_t seqState;
  logic [RAILS*SW-1:0]     seqSlots;
  logic [SW-1:0]           curSlot;
  logic [CNT_W-1:0]        stepCnt;
  logic                    bypassed;
  logic [RAILS-1:0]        stepMask;
  logic                    seqIdle;

  assign seqIdle = (seqState == rps_pkg::SEQ_IDLE);

  // Rails whose slot equals the slot under way
  for (genvar g = 0; g < RAILS; g++) begin : g_match
    assign stepMask[g] = (seqSlots[g*SW +: SW] == curSlot); // see [R07]
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  rps_pkg::rps_bus_state_t busState;
  logic [31:0]             statusWord;
  logic                    wrAllowed;

  always_comb begin
    statusWord = 32'h0;
    statusWord[`RPS_ST_SLOT_LSB +: SW]    = curSlot;
    statusWord[`RPS_ST_BUSY_BIT]          = seqBusy;
    statusWord[`RPS_ST_BYPASS_BIT]        = bypassed;
    statusWord[`RPS_ST_DONE_BIT]          = (seqState == rps_pkg::SEQ_DONE);
    statusWord[`RPS_ST_SYSON_BIT]         = systemOn;
    statusWord[`RPS_ST_OFF_LSB +: RAILS]  = railOff;
  end

  // Writes outside system-on or mid-sequence are dropped silently
  assign wrAllowed = systemOn && seqIdle; // see [R05]

  assign slotBus.rdRail   = reqRail[2:0];
  assign slotBus.wrRail   = reqRail[2:0];
  assign slotBus.wrData   = avs_writedata[SW-1:0]; // see [R03]
  assign slotBus.wrEn     = (busState == rps_pkg::BUS_ANSW) && avs_write
                            && reqAligned && reqRail[3]
                            && avs_byteenable[0] && wrAllowed;
  assign slotBus.loadEn   = cfgLoad; // see [R04]
  assign slotBus.loadData = fusedOnSlots;

  // Fixed latency: waitrequest drops two edges after the request
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busState        <= rps_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      case (busState)
        rps_pkg::BUS_IDLE: begin
          avs_waitrequest <= 1'b1;
          if (avs_read || avs_write) begin
            busState <= rps_pkg::BUS_FETCH;
          end
        end
        rps_pkg::BUS_FETCH: begin
          avs_waitrequest <= 1'b0;
          busState        <= rps_pkg::BUS_ANSW;
          if (!avs_read || !reqAligned) begin
            avs_readdata <= 32'h0;
          end else if (reqRail[3]) begin
            // Upper bits of a slot register read as zero
            avs_readdata <= {29'h0, slotBus.rdData}; // see [R03]
          end else if (reqIdx == `RPS_IDX_STATUS) begin
            avs_readdata <= statusWord;
          end else begin
            avs_readdata <= 32'h0;
          end
        end
        rps_pkg::BUS_ANSW: begin
          avs_waitrequest <= 1'b1;
          busState        <= rps_pkg::BUS_IDLE;
        end
        default: begin
          avs_waitrequest <= 1'b1;
          busState        <= rps_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power-up order mirror
  // ----------------------------------------------------------------
  // Bus writes never reach this copy
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      upOrderSlots <= 21'h0;
    end else if (cfgLoad) begin
      upOrderSlots <= fusedOnSlots; // see [R06]
    end
  end

  // ----------------------------------------------------------------
  // Power-down sequencer
  // ----------------------------------------------------------------
  logic trigger;
  logic allZero;
  logic inStep;
  logic inHold;
  logic holdEnd;
  logic emptyStep;
  logic lastSlot;
  logic stepDone;

  assign trigger   = seqIdle && powerDownReq;
  assign allZero   = (slotBus.slots == '0); // see [R02]
  assign inStep    = (seqState == rps_pkg::SEQ_STEP);
  assign inHold    = (seqState == rps_pkg::SEQ_HOLD);
  assign holdEnd   = inHold && (stepCnt == '0);
  assign emptyStep = inStep && !(|stepMask);
  assign lastSlot  = (curSlot == 3'h0);
  // Slot finished after its interval, or at once when empty
  assign stepDone  = emptyStep || holdEnd;

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n || cfgLoad) begin
      seqState <= rps_pkg::SEQ_IDLE;
    end else begin
      case (seqState)
        rps_pkg::SEQ_IDLE: begin
          if (powerDownReq && allZero) begin
            seqState <= rps_pkg::SEQ_DONE;
          end else if (powerDownReq) begin
            seqState <= rps_pkg::SEQ_STEP;
          end
        end
        rps_pkg::SEQ_STEP: begin
          if (|stepMask) begin
            seqState <= rps_pkg::SEQ_HOLD;
          end else if (lastSlot) begin
            seqState <= rps_pkg::SEQ_DONE;
          end
        end
        rps_pkg::SEQ_HOLD: begin
          if (holdEnd && lastSlot) begin
            seqState <= rps_pkg::SEQ_DONE;
          end else if (holdEnd) begin
            seqState <= rps_pkg::SEQ_STEP;
          end
        end
        rps_pkg::SEQ_DONE: begin
          // Rails stay off until the next configuration load
          if (!powerDownReq) begin
            seqState <= rps_pkg::SEQ_IDLE;
          end
        end
        default: begin
          seqState <= rps_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Slots are snapshotted at the trigger so a late write cannot
  // reorder a sequence already under way
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seqSlots <= '0;
    end else if (trigger && !cfgLoad) begin
      seqSlots <= slotBus.slots;
    end
  end

  // Slot under way, counted down from the top
  always_ff @(posedge core_clk) begin
    if (!rst_n || cfgLoad) begin
      curSlot <= `RPS_SLOT_RESET;
    end else if (trigger && !allZero) begin
      curSlot <= `RPS_SLOT_MAX; // see [R01]
    end else if (stepDone && !lastSlot) begin
      // Empty slots cost one cycle, not an interval
      curSlot <= curSlot - 3'h1; // see [R01]
    end
  end

  // Interval counter of the slot under way
  always_ff @(posedge core_clk) begin
    if (!rst_n || cfgLoad) begin
      stepCnt <= '0;
    end else if (inStep && (|stepMask)) begin
      stepCnt <= CNT_W'(STEP_CYCLES - 1); // see [R07]
    end else if (inHold && !holdEnd) begin
      stepCnt <= stepCnt - CNT_W'(1);
    end
  end

  // Bypass flag, kept until the next load or trigger
  always_ff @(posedge core_clk) begin
    if (!rst_n || cfgLoad) begin
      bypassed <= 1'b0;
    end else if (trigger) begin
      bypassed <= allZero; // see [R02]
    end
  end

  // Busy from a trigger with any nonzero slot to the end of slot zero; never set on the bypass
  always_ff @(posedge core_clk) begin
    if (!rst_n || cfgLoad) begin
      seqBusy <= 1'b0;
    end else if (trigger && !allZero) begin
      seqBusy <= 1'b1;
    end else if (stepDone && lastSlot) begin
      seqBusy <= 1'b0;
    end
  end

  // Rail off commands, cleared only by reset or load
  always_ff @(posedge core_clk) begin
    if (!rst_n || cfgLoad) begin
      railOff <= 7'h00;
    end else if (trigger && allZero) begin
      railOff <= 7'h7F; // see [R02]
    end else if (inStep) begin
      railOff <= railOff | stepMask; // see [R07]
    end
  end

endmodule : rps_sequencer

`default_nettype wire

/* verif/rps_sequencer_asserts.sv */
/* Port checker of the rail power-down sequencer.
   Assumes it is bound onto rps_sequencer. */
`timescale 1ns/1ps
`default_nettype none
module rps_seq_asserts #(
  parameter int STEP_CYCLES = 4
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Bus
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Sequencer
  input wire logic        cfgLoad,
  input wire logic        powerDownReq,
  input wire logic [20:0] fusedOnSlots,
  input wire logic [6:0]  railOff,
  input wire logic        seqBusy,
  input wire logic [20:0] upOrderSlots
);
  logic [15:0] gapCnt;
  logic [6:0]  lastOff;
  logic        sawStep;
  logic        offMoved;
  assign offMoved = railOff != lastOff;
  // Stable cycles since the last rail change
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gapCnt  <= 16'h0000;
      lastOff <= 7'h00;
      sawStep <= 1'b0;
    end else begin
      lastOff <= railOff;
      gapCnt  <= offMoved ? 16'h0000 : gapCnt + 16'h0001;
      sawStep <= seqBusy & (sawStep | offMoved);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    $past(rst_n) && $rose(avs_read || avs_write);
  endsequence
  sequence s_answer;
    avs_waitrequest [*2] ##1 !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_bus_time;
    s_taken |-> s_answer;
  endproperty
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_upper;
    avs_read && !avs_waitrequest && avs_address[9:2] != 8'h6A
      |-> avs_readdata[31:3] == 29'h0;
  endproperty
  property p_off_keep;
    $past(rst_n) && !$past(cfgLoad)
      |-> ($past(railOff) & ~railOff) == 7'h00;
  endproperty
  property p_off_cause;
    $past(rst_n) && !$past(cfgLoad) && railOff != $past(railOff)
      |-> $past(seqBusy) || ($past(powerDownReq) && railOff == 7'h7F
          && $past(railOff) == 7'h00);
  endproperty
  property p_bypass;
    $past(rst_n) && !$past(seqBusy) && $past(railOff) == 7'h00
      && railOff == 7'h7F |-> !seqBusy;
  endproperty
  property p_gap;
    seqBusy && sawStep && offMoved |-> gapCnt >= STEP_CYCLES;
  endproperty
  property p_load;
    cfgLoad |=> upOrderSlots == $past(fusedOnSlots) && railOff == 7'h00;
  endproperty
  property p_up_keep;
    $past(rst_n) && !$past(cfgLoad) |-> $stable(upOrderSlots);
  endproperty
  a_bus_time: assert property (p_bus_time)
    else $error("bus answer late");
  a_wait_one: assert property (p_wait_one)
    else $error("wait low too long");
  a_upper: assert property (p_upper)
    else $error("unused bits set");
  a_off_keep: assert property (p_off_keep)
    else $error("rail back on");
  a_off_cause: assert property (p_off_cause)
    else $error("stray off");
  a_bypass: assert property (p_bypass)
    else $error("bypass busy");
  a_gap: assert property (p_gap)
    else $error("step too short");
  a_load: assert property (p_load)
    else $error("load missed");
  a_up_keep: assert property (p_up_keep)
    else $error("up order moved");
endmodule : rps_seq_asserts
bind rps_sequencer rps_seq_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .cfgLoad, .powerDownReq, .fusedOnSlots, .railOff,
  .seqBusy, .upOrderSlots);
`default_nettype wire

/* verif/tb_rps_sequencer.sv */
/* Self-checking bench of the rail power-down sequencer.
   Assumes a step count of 4 to keep sequences short. */
`timescale 1ns/1ps
`default_nettype none
module tb_rps_sequencer;
  logic        core_clk, rst_n, avs_read, avs_write, systemOn, cfgLoad;
  logic        powerDownReq, avs_waitrequest, seqBusy;
  logic [3:0]  avs_byteenable;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, lf;
  logic [20:0] fusedOnSlots, upOrderSlots, cur;
  logic [6:0]  railOff, prevOff;
  logic [31:0] rdQ[$];
  logic [6:0]  offQ[$];
  int          miscompares, cmp_count, n;
  rps_sequencer #(.STEP_CYCLES(4)) dut (.core_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .systemOn, .powerDownReq, .cfgLoad, .fusedOnSlots,
    .railOff, .seqBusy, .upOrderSlots);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [9:0] sa(input int r);
    return 10'h17C + 10'(4 * r);
  endfunction : sa
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  task automatic tmo();
    miscompares++;
    $display("[FAIL] %0t wait ran out", $time);
    stop_test();
  endtask : tmo
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string kind);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, kind, got, exp);
    end
  endtask : cmp
  task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp, "read data");
  endtask : cmp_read
  task automatic cmp_off(input logic [6:0] got, input logic [6:0] exp);
    cmp(32'(got), 32'(exp), "rails off");
  endtask : cmp_off
  task automatic cmp_order(input logic [20:0] got, input logic [20:0] exp);
    cmp(32'(got), 32'(exp), "up order");
  endtask : cmp_order
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d);
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) tmo();
    @(posedge core_clk);
  endtask : bus
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic load(input logic [20:0] f);
    fusedOnSlots <= f;
    cfgLoad      <= 1'b1;
    @(posedge core_clk);
    cfgLoad <= 1'b0;
    @(posedge core_clk);
    cur = f;
    cmp_order(upOrderSlots, f);
  endtask : load
  task automatic pdown();
    logic [6:0] acc, st;
    acc = 7'h00;
    // Highest slot first, equal slots in one step
    for (int s = 7; s >= 0; s--) begin
      for (int r = 0; r < 7; r++) st[r] = cur[3*r+:3] == 3'(s);
      acc = acc | st;
      if (st != 7'h00) offQ.push_back(acc);
    end
    powerDownReq <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(railOff === 7'h7F && seqBusy === 1'b0) && n < 400);
    if (n >= 400) tmo();
    powerDownReq <= 1'b0;
    offQ.push_back(7'h00);
    @(posedge core_clk);
  endtask : pdown
  // Watcher: oldest note against each result
  always @(posedge core_clk) begin
    if (rst_n === 1'b1 && avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      cmp_read(avs_readdata, rdQ.size() > 0 ? rdQ.pop_front() : 'x);
    end
    if (rst_n === 1'b1 && railOff !== prevOff) begin
      cmp_off(railOff,
              offQ.size() > 0 ? offQ.pop_front() : 'x);
      prevOff = railOff;
    end
  end
  initial begin
    {rst_n, avs_read, avs_write, powerDownReq, cfgLoad} = 5'h00;
    systemOn       = 1'b1;
    avs_byteenable = 4'hF;
    avs_address    = 10'h000;
    avs_writedata  = 32'h0;
    fusedOnSlots   = 21'h0;
    prevOff        = 7'h00;
    miscompares    = 0;
    cmp_count      = 0;
    lf             = 32'h42F4;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    cmp_order(upOrderSlots, 21'h0);
    rd(sa(4), 32'h0);
    // Last pass loads all zero slots to force the bypass
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      load(k == 3 ? 21'h0 : lf[20:0]);
      for (int r = 0; r < 7; r++) rd(sa(r), 32'(cur[3*r+:3]));
      systemOn <= 1'b0;
      bus(1'b1, sa(5), ~32'(cur[17:15]));
      systemOn <= 1'b1;
      rd(sa(5), 32'(cur[17:15]));
      if (k == 1 || k == 2) begin
        for (int r = 0; r < 7; r++) begin
          lf = lfsr(lf);
          bus(1'b1, sa(r), lf);
          cur[3*r+:3] = lf[2:0];
        end
        for (int r = 0; r < 7; r++) rd(sa(r), 32'(cur[3*r+:3]));
        cmp_order(upOrderSlots, fusedOnSlots);
      end
      rd(10'h3FC, 32'h0);
      // Status idle after a load: only the system-on bit
      rd(10'h1A8, 32'h0000_0040);
      pdown();
      rd(10'h1A8, k == 3 ? 32'h0000_7F50 : 32'h0000_7F40);
    end
    load(21'h0);
    // Let the watcher take the last rail note first
    @(posedge core_clk);
    cmp(32'(offQ.size() + rdQ.size()), 32'h0, "notes left");
    stop_test();
  end
endmodule : tb_rps_sequencer
`default_nettype wire
